// File: rtl/two_wire_pkg.sv
// Shared constants and types for the two-wire master transmitter
package two_wire_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTL  = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_DIV  = 8'h0c;
    localparam logic [7:0] OFS_MODE = 8'h10;

    // two_wire_control bit positions
    localparam int CTL_FLAG  = 7;
    localparam int CTL_ACK   = 6;
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_WCOL  = 3;
    localparam int CTL_EN    = 2;
    localparam int CTL_RSVD  = 1;
    localparam int CTL_IE    = 0;

    // Mode register field positions
    localparam int MODE_PERMIT_LSB = 0;
    localparam int MODE_CUR_LSB    = 4;

    // Values after reset
    localparam logic [4:0] RST_CODE   = 5'h1f;
    localparam logic [7:0] RST_DATA   = 8'hff;
    localparam logic [7:0] RST_DIV    = 8'h07;
    localparam logic [3:0] RST_PERMIT = 4'hf;

    // Status codes, as seen after masking the prescaler bits
    localparam logic [7:0] STAT_MASK      = 8'hf8;
    localparam logic [7:0] CODE_START     = 8'h08;
    localparam logic [7:0] CODE_RSTART    = 8'h10;
    localparam logic [7:0] CODE_ADDR_ACK  = 8'h18;
    localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
    localparam logic [7:0] data_acked_code = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST  = 8'h38;

    // Direction bit on the data line
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ  = 1'b1;

    typedef enum logic [3:0] {
        eng_idle, eng_wait_free, eng_start_hi, eng_start_lo, eng_hold,
        eng_rs_lo, eng_bit_lo, eng_bit_hi, eng_ack_lo, eng_ack_hi,
        eng_stop_lo, eng_stop_hi, eng_stop_end
    } eng_t;

    typedef enum logic [2:0] {
        mode_none, master_tx_mode, master_rx_mode, slave_tx_mode,
        slave_rx_mode
    } mode_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        scl_s1;
        logic        scl_s2;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_prev;
        logic        scl_o;
        logic        sda_o;
        logic        scl_oe_n;
        logic        sda_oe_n;
        logic        flag;
        logic        ack_enable_bit;
        logic        start_request_bit;
        logic        stop_req;
        logic        write_collision_bit;
        logic        enable;
        logic        irq_enable_bit;
        logic [4:0]  code;
        logic [1:0]  presc;
        logic [7:0]  data;
        logic [7:0]  div;
        logic [3:0]  permit;
        mode_t       mode;
        eng_t        eng;
        logic [7:0]  cnt;
        logic [2:0]  bitn;
        logic        is_addr;
        logic        is_master;
        logic        busy;
    } core_t;

endpackage

// File: rtl/two_wire_master_transmitter.sv
// Two-wire bus master transmitter with APB register access
`timescale 1ns/1ps

// Summary of operation
// - Four modes exist; a master start needs permit bit 0 or 1 set, and permit bits 2 and 3 gate nothing.
// - Master work starts after START; address direction bit picks tx or rx.
// - Read direction is a high data line, write direction a low one.
// - Ninth bit low means acknowledge, high means not-acknowledge.
// - Every item after the address is one eight-bit byte.
// - While the flag is set the transfer stalls with the clock held low.
// - Writing one to the flag bit clears the flag.
// - Status code sits in upper five bits; mask 0xf8 before comparing.
// - Enable bit must be set; when clear no bus activity happens.
// - Start, enable and flag written together start once bus is free.
// - After START the flag sets and status reads 0x08.
// - After address byte and ack bit: 0x18, 0x20 or 0x38.
// - Data write while flag low is dropped and collision bit sets.
// - After a data byte and its ack bit the flag sets, code updates.
// - Data byte acked reports 0x28, not acked reports 0x30.
// - Stop request with flag sends STOP, then hardware clears the request.
// - Start plus stop sends STOP then START; repeated START reports 0x10.
// - Arbitration loss releases bus, goes unaddressed slave; start retries.
module two_wire_master_transmitter
    import two_wire_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n
);

    core_t q, n;
    logic  hw_set, setup, wr, wr_ctl, wr_data;
    logic  mapped, half_done, high_done;

    assign setup     = psel && !penable && !q.pready;
    assign wr        = psel && penable && q.pready && pwrite;
    assign wr_ctl    = wr && (paddr == OFS_CTL);
    assign wr_data   = wr && (paddr == OFS_DATA);
    assign mapped    = (paddr == OFS_CTL) || (paddr == OFS_STAT) ||
                       (paddr == OFS_DATA) || (paddr == OFS_DIV) ||
                       (paddr == OFS_MODE);
    assign half_done = (q.cnt == q.div);
    // High phases count only once the line is seen high: slaves may stretch
    assign high_done = q.scl_s2 && half_done;

    always_comb begin
        n      = q;
        hw_set = 1'b0;
        // Two-stage synchronisers for the bus lines
        n.scl_s1   = scl_i;
        n.scl_s2   = q.scl_s1;
        n.sda_s1   = sda_i;
        n.sda_s2   = q.sda_s1;
        n.sda_prev = q.sda_s2;
        n.cnt      = q.cnt + 8'h01;
        // Bus busy tracking from observed START and STOP conditions
        if (q.scl_s2 && q.sda_prev && !q.sda_s2) n.busy = 1'b1;
        else if (q.scl_s2 && !q.sda_prev && q.sda_s2) n.busy = 1'b0;

        case (q.eng)
            eng_idle: begin
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b1;
                n.cnt      = 8'h00;
                if (!q.flag && q.stop_req && !q.start_request_bit)
                    n.stop_req = 1'b0;
                if (q.enable && !q.flag && q.start_request_bit &&
                    (q.permit[0] || q.permit[1])) begin
                    n.eng = eng_wait_free;
                end
            end
            eng_wait_free: begin
                n.cnt = 8'h00;
                if (!q.busy && q.scl_s2 && q.sda_s2) begin
                    n.eng = eng_start_hi;
                end
            end
            eng_start_hi: begin
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b1;
                if (!q.scl_s2) begin
                    n.cnt = 8'h00;
                end else if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_start_lo;
                end
            end
            eng_start_lo: begin
                n.sda_oe_n = 1'b0;
                if (half_done) begin
                    n.scl_oe_n  = 1'b0;
                    n.cnt       = 8'h00;
                    n.eng       = eng_hold;
                    hw_set      = 1'b1;
                    n.code      = q.is_master ? CODE_RSTART[7:3] :
                                                CODE_START[7:3];
                    n.is_master = 1'b1;
                    n.is_addr   = 1'b1;
                end
            end
            eng_hold: begin
                // Clock held low stalls every party on the bus
                n.scl_oe_n = 1'b0;
                n.cnt      = 8'h00;
                if (!q.flag) begin
                    if (q.stop_req) begin
                        n.eng = eng_stop_lo;
                    end else if (q.start_request_bit) begin
                        n.eng = eng_rs_lo;
                    end else begin
                        n.eng  = eng_bit_lo;
                        n.bitn = 3'd7;
                    end
                end
            end
            eng_rs_lo: begin
                n.scl_oe_n = 1'b0;
                n.sda_oe_n = 1'b1;
                if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_start_hi;
                end
            end
            eng_bit_lo: begin
                n.scl_oe_n = 1'b0;
                // Data moves only once the clock is driven low, never under
                // a high clock; bit 0 of the address is the direction
                if (!q.scl_oe_n) n.sda_oe_n = q.data[q.bitn];
                if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_bit_hi;
                end
            end
            eng_bit_hi: begin
                n.scl_oe_n = 1'b1;
                if (!q.scl_s2) begin
                    n.cnt = 8'h00;
                end else if (half_done) begin
                    n.cnt = 8'h00;
                    if (q.sda_oe_n && !q.sda_s2) begin
                        // Another master pulled low while we released
                        n.eng       = eng_idle;
                        n.scl_oe_n  = 1'b1;
                        n.sda_oe_n  = 1'b1;
                        hw_set      = 1'b1;
                        n.code      = CODE_ARB_LOST[7:3];
                        n.is_master = 1'b0;
                        n.mode      = slave_rx_mode;
                    end else if (q.bitn == 3'd0) begin
                        n.eng = eng_ack_lo;
                    end else begin
                        n.bitn = q.bitn - 3'd1;
                        n.eng  = eng_bit_lo;
                    end
                end
            end
            eng_ack_lo: begin
                n.scl_oe_n = 1'b0;
                if (!q.scl_oe_n) n.sda_oe_n = 1'b1;
                if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_ack_hi;
                end
            end
            eng_ack_hi: begin
                n.scl_oe_n = 1'b1;
                if (!q.scl_s2) begin
                    n.cnt = 8'h00;
                end else if (half_done) begin
                    n.cnt      = 8'h00;
                    n.scl_oe_n = 1'b0;
                    n.eng      = eng_hold;
                    hw_set     = 1'b1;
                    n.is_addr  = 1'b0;
                    if (q.is_addr) begin
                        n.mode = (q.data[0] == DIR_READ) ? master_rx_mode :
                                                           master_tx_mode;
                        n.code = q.sda_s2 ? CODE_ADDR_NACK[7:3] :
                                            CODE_ADDR_ACK[7:3];
                    end else begin
                        n.code = q.sda_s2 ? CODE_DATA_NACK[7:3] :
                                            data_acked_code[7:3];
                    end
                end
            end
            eng_stop_lo: begin
                n.scl_oe_n = 1'b0;
                n.sda_oe_n = 1'b0;
                if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_stop_hi;
                end
            end
            eng_stop_hi: begin
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b0;
                if (!q.scl_s2) begin
                    n.cnt = 8'h00;
                end else if (half_done) begin
                    n.cnt = 8'h00;
                    n.eng = eng_stop_end;
                end
            end
            eng_stop_end: begin
                n.sda_oe_n = 1'b1;
                if (half_done) begin
                    // A pending start is taken up again from idle
                    n.eng       = eng_idle;
                    n.stop_req  = 1'b0;
                    n.is_master = 1'b0;
                    n.mode      = mode_none;
                end
            end
            default: n.eng = eng_idle;
        endcase

        // Disabled: the lines are released and nothing is generated
        if (!q.enable) begin
            n.eng       = eng_idle;
            n.scl_oe_n  = 1'b1;
            n.sda_oe_n  = 1'b1;
            n.is_master = 1'b0;
            n.busy      = 1'b0;
            hw_set      = 1'b0;
        end

        // APB slave: one wait-free access phase after the setup cycle
        n.pready  = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            n.pslverr = !mapped;
            n.prdata  = 32'h0000_0000;
            case (paddr)
                OFS_CTL: begin
                    n.prdata[CTL_FLAG]  = q.flag;
                    n.prdata[CTL_ACK]   = q.ack_enable_bit;
                    n.prdata[CTL_START] = q.start_request_bit;
                    n.prdata[CTL_STOP]  = q.stop_req;
                    n.prdata[CTL_WCOL]  = q.write_collision_bit;
                    n.prdata[CTL_EN]    = q.enable;
                    n.prdata[CTL_RSVD]  = 1'b0;
                    n.prdata[CTL_IE]    = q.irq_enable_bit;
                end
                OFS_STAT: n.prdata[7:0] = {q.code, 1'b0, q.presc};
                OFS_DATA: n.prdata[7:0] = q.data;
                OFS_DIV:  n.prdata[7:0] = q.div;
                OFS_MODE: begin
                    n.prdata[MODE_PERMIT_LSB +: 4] = q.permit;
                    n.prdata[MODE_CUR_LSB +: 3]    = q.mode;
                end
                default:  n.prdata = 32'h0000_0000;
            endcase
        end

        if (wr_ctl) begin
            n.ack_enable_bit    = pwdata[CTL_ACK];
            n.start_request_bit = pwdata[CTL_START];
            n.stop_req          = pwdata[CTL_STOP];
            n.enable            = pwdata[CTL_EN];
            n.irq_enable_bit    = pwdata[CTL_IE];
        end
        if (wr && (paddr == OFS_STAT)) n.presc = pwdata[1:0];
        if (wr_data) begin
            if (q.flag) begin
                n.data                = pwdata[7:0];
                n.write_collision_bit = 1'b0;
            end else begin
                n.write_collision_bit = 1'b1;
            end
        end
        if (wr && (paddr == OFS_DIV)) n.div = pwdata[7:0];
        if (wr && (paddr == OFS_MODE)) begin
            n.permit = pwdata[MODE_PERMIT_LSB +: 4];
        end
        // Write-one clears the flag; a hardware set in the same cycle wins
        n.flag = (q.flag && !(wr_ctl && pwdata[CTL_FLAG])) || hw_set;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q          <= '0;
            q.scl_s1   <= 1'b1;
            q.scl_s2   <= 1'b1;
            q.sda_s1   <= 1'b1;
            q.sda_s2   <= 1'b1;
            q.sda_prev <= 1'b1;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.code     <= RST_CODE;
            q.data     <= RST_DATA;
            q.div      <= RST_DIV;
            q.permit   <= RST_PERMIT;
        end else begin
            q <= n;
        end
    end

    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;
    assign scl_o    = q.scl_o;
    assign sda_o    = q.sda_o;
    assign scl_oe_n = q.scl_oe_n;
    assign sda_oe_n = q.sda_oe_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_hold_stalls: assert property (
        (q.eng == eng_hold) && q.flag && q.enable && !wr_ctl
        |=> (q.eng == eng_hold) && !q.scl_oe_n)
        else $error("Transfer moved on while flag set");
    a_flag_write_clear: assert property (
        wr_ctl && pwdata[CTL_FLAG] && !hw_set |=> !q.flag)
        else $error("Flag not cleared by writing one");
    a_start_code: assert property (
        (q.eng == eng_start_lo) && half_done && q.enable && !q.is_master
        |=> q.flag && (q.code == CODE_START[7:3]) && !q.scl_oe_n)
        else $error("Start did not report its code");
    a_rstart_code: assert property (
        (q.eng == eng_start_lo) && half_done && q.enable && q.is_master
        |=> q.flag && (q.code == CODE_RSTART[7:3]))
        else $error("Repeated start did not report its code");
    a_collision_drop: assert property (
        wr_data && !q.flag && !hw_set
        |=> q.write_collision_bit && (q.data == $past(q.data)))
        else $error("Data write with flag low not dropped");
    a_off_quiet: assert property (
        !q.enable |=> q.scl_oe_n && q.sda_oe_n && (q.eng == eng_idle))
        else $error("Bus driven while disabled");
    a_ack_codes: assert property (
        (q.eng == eng_ack_hi) && high_done && q.enable
        |=> q.flag && (q.code == ($past(q.is_addr) ?
            ($past(q.sda_s2) ? CODE_ADDR_NACK[7:3] : CODE_ADDR_ACK[7:3]) :
            ($past(q.sda_s2) ? CODE_DATA_NACK[7:3] : data_acked_code[7:3]))))
        else $error("Wrong code after acknowledge bit");
    a_arb_release: assert property (
        (q.eng == eng_bit_hi) && high_done && q.sda_oe_n && !q.sda_s2 &&
        q.enable
        |=> (q.code == CODE_ARB_LOST[7:3]) && q.scl_oe_n && q.sda_oe_n &&
            (q.mode == slave_rx_mode) && q.flag)
        else $error("Arbitration loss not handled");
    a_stop_clears: assert property (
        (q.eng == eng_stop_end) && half_done && q.enable && !wr_ctl
        |=> !q.stop_req && (q.eng == eng_idle))
        else $error("Stop request not cleared after stop");
    a_rsvd_zero: assert property (
        setup && (paddr == OFS_CTL) |=> (q.prdata[CTL_RSVD] == 1'b0))
        else $error("Reserved control bit reads nonzero");

endmodule // two_wire_master_transmitter

// File: testbench/two_wire_slave_model.sv
// Slave receiver model for the two-wire bus
`timescale 1ns/1ps
module two_wire_slave_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_addr,
    input  wire logic       ack_data,
    input  wire logic       stretch,
    input  wire logic       arb_lose,
    output logic            scl_rel,
    output logic            sda_rel,
    output logic [7:0]      rx_byte,
    output int              stops
);
    logic       scl_q, sda_q, ack_pull, hold, first;
    logic [3:0] bitc;
    logic [7:0] sh;
    int         st_cnt;

    // Released lines float up to the pull-up level
    assign scl_rel = (st_cnt == 0);
    assign sda_rel = !(ack_pull || hold);
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (srst) begin
            {ack_pull, hold, first, bitc, sh, rx_byte} <= '0;
            st_cnt <= 0;
            stops  <= 0;
        end else begin
            if (st_cnt > 0) st_cnt <= st_cnt - 1;
            if (scl && scl_q && sda_q && !sda) begin
                bitc  <= 4'd0;
                first <= 1'b1;
            end
            if (scl && scl_q && !sda_q && sda) stops <= stops + 1;
            if (scl && !scl_q && bitc < 4'd8) begin
                sh   <= {sh[6:0], sda};
                bitc <= bitc + 4'd1;
            end
            if (!scl && scl_q) begin
                // Slow answers: hold the clock low after each fall
                if (stretch) st_cnt <= 20;
                if (bitc == 4'd8) begin
                    ack_pull <= first ? ack_addr : ack_data;
                    rx_byte  <= sh;
                    bitc     <= 4'd9;
                end else if (bitc == 4'd9) begin
                    ack_pull <= 1'b0;
                    bitc     <= 4'd0;
                    first    <= 1'b0;
                end
            end
            // A rival master starts pulling data low while the clock is low and holds it until arb_lose drops
            if (arb_lose && !scl) hold <= 1'b1;
            if (!arb_lose) hold <= 1'b0;
        end
    end
endmodule // two_wire_slave_model

// File: testbench/tb_two_wire_master_transmitter.sv
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
module tb_two_wire_master_transmitter
    import two_wire_pkg::*;
;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, rx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel;
    logic        ack_addr, ack_data, stretch, arb_lose;
    int          stops, n, fail_count, total_checks, cyc, act;
    wire         scl_w = scl_oe_n & scl_rel;
    wire         sda_w = sda_oe_n & sda_rel;

    two_wire_master_transmitter i_dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n));
    two_wire_slave_model i_slave (.clk(clk), .srst(srst), .scl(scl_w),
        .sda(sda_w), .ack_addr(ack_addr), .ack_data(ack_data),
        .stretch(stretch), .arb_lose(arb_lose), .scl_rel(scl_rel),
        .sda_rel(sda_rel), .rx_byte(rx_byte), .stops(stops));

    always #5 clk = ~clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cycle ceiling, and a count of cycles with the DUT pulling a line low
    always @(posedge clk) begin
        cyc++;
        if (scl_oe_n === 1'b0 || sda_oe_n === 1'b0) act++;
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ereg(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic estat(input logic [7:0] code);
        apb(1'b0, OFS_STAT, 32'h0);
        check("status", rd & 32'hf8, {24'h0, code});
    endtask

    // Polls the control register; the flag must come within the bound
    task automatic wait_flag();
        for (int i = 0; i < 400 && rd[CTL_FLAG] !== 1'b1; i++) begin
            apb(1'b0, OFS_CTL, 32'h0);
        end
        check("flag", {31'h0, rd[CTL_FLAG]}, 32'h1);
    endtask

    task automatic xfer(input logic [7:0] d, input logic [7:0] code);
        apb(1'b1, OFS_DATA, {24'h0, d});
        apb(1'b1, OFS_CTL, 32'h84);
        rd = '0;
        wait_flag();
        estat(code);
    endtask

    task automatic quiet(input string nm, input int exp);
        @(negedge clk);
        act = 0;
        repeat (100) @(negedge clk);
        check(nm, 32'(act), 32'(exp));
    endtask

    task automatic start_op(input logic [31:0] c, input logic [7:0] code);
        apb(1'b1, OFS_CTL, c);
        rd = '0;
        wait_flag();
        estat(code);
    endtask

    initial begin
        clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; ack_addr = 1; ack_data = 1;
        stretch = 0; arb_lose = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        ereg("ctl", OFS_CTL, 32'h00);
        ereg("stat", OFS_STAT, 32'hf8);
        ereg("data", OFS_DATA, 32'hff);
        ereg("mode", OFS_MODE, 32'h0f);
        apb(1'b0, 8'h40, 32'h0);
        check("slverr", {31'h0, er}, 32'h1);
        $display("test registers done");
        apb(1'b1, OFS_CTL, 32'ha3);
        ereg("ctl spare", OFS_CTL, 32'h21);
        quiet("disabled", 0);
        apb(1'b1, OFS_DATA, 32'h11);
        ereg("wcol", OFS_CTL, 32'h29);
        ereg("data kept", OFS_DATA, 32'hff);
        apb(1'b1, OFS_MODE, 32'h0c);
        apb(1'b1, OFS_CTL, 32'ha4);
        quiet("no permit", 0);
        apb(1'b1, OFS_CTL, 32'h00);
        apb(1'b1, OFS_MODE, 32'h0f);
        $display("test guards done");
        start_op(32'ha4, CODE_START);
        quiet("stall", 100);
        xfer(8'ha4, CODE_ADDR_ACK);
        check("addr", {24'h0, rx_byte}, 32'ha4);
        stretch <= 1'b1;
        xfer(8'h5a, data_acked_code);
        check("byte", {24'h0, rx_byte}, 32'h5a);
        stretch <= 1'b0;
        ack_data <= 1'b0;
        xfer(8'hc3, CODE_DATA_NACK);
        $display("test write done");
        start_op(32'ha4, CODE_RSTART);
        ack_addr <= 1'b0;
        xfer(8'h3c, CODE_ADDR_NACK);
        ack_addr <= 1'b1;
        start_op(32'ha4, CODE_RSTART);
        xfer(8'ha5, CODE_ADDR_ACK);
        ereg("mode rx", OFS_MODE, 32'h2f);
        check("dir", {31'h0, rx_byte[0]}, 32'h1);
        n = stops;
        start_op(32'hb4, CODE_START);
        check("stop", 32'(stops - n), 32'd1);
        $display("test restart done");
        arb_lose <= 1'b1;
        xfer(8'hff, CODE_ARB_LOST);
        ereg("mode slave", OFS_MODE, 32'h4f);
        check("released", {30'h0, scl_oe_n, sda_oe_n}, 32'h3);
        check("drive", {30'h0, scl_o, sda_o}, 32'h0);
        arb_lose <= 1'b0;
        start_op(32'ha4, CODE_START);
        n = stops;
        apb(1'b1, OFS_CTL, 32'h94);
        repeat (100) @(posedge clk);
        ereg("stop bit", OFS_CTL, 32'h04);
        check("stop sent", 32'(stops - n), 32'd1);
        $display("test arbitration done");
        give_verdict();
    end
endmodule // tb_two_wire_master_transmitter
